// ---- hdl/brc_rtc_core.sv ----
// Real-time clock core with calendar, alarm, periodic rates and an APB register port
`timescale 1ns/100ps
module brc_rtc_core #(
  parameter int CLK_HZ = 25000000
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic powerFail,
  output logic squareWaveOut,
  output logic irqOut,
  output logic irqOe
);
  localparam logic [25:0] ACC_STEP = 26'(brc_pkg::OSC_HZ);
  localparam logic [25:0] ACC_LIMIT = 26'(CLK_HZ);

  // Coding helpers
  function automatic logic [7:0] toBin(input logic [7:0] b, input logic bin);
    return bin ? b : 8'(8'(b[7:4]) * 8'd10 + {4'h0, b[3:0]});
  endfunction
  function automatic logic [7:0] fromBin(input logic [7:0] v, input logic bin);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'd10;
    ones = v % 8'd10;
    return bin ? v : {tens[3:0], ones[3:0]};
  endfunction
  // Hours to 0..23, honouring afternoon bit in 12-hour form
  function automatic logic [7:0] hourToBin(input logic [7:0] h, input logic bin, input logic h24);
    logic [7:0] v;
    v = toBin({1'b0, h[6:0]}, bin);
    if (h24) begin
      return toBin(h, bin);
    end
    return 8'((v == 8'd12 ? 8'd0 : v) + (h[7] ? 8'd12 : 8'd0));
  endfunction
  function automatic logic [7:0] binToHour(input logic [7:0] v, input logic bin, input logic h24);
    logic [7:0] v12;
    logic [7:0] coded;
    v12 = (v % 8'd12 == 8'd0) ? 8'd12 : v % 8'd12;
    coded = fromBin(v12, bin);
    return h24 ? fromBin(v, bin) : {(v >= 8'd12), coded[6:0]};
  endfunction
  function automatic logic [7:0] daysIn(input logic [7:0] mon, input logic [7:0] yr);
    case (mon)
      8'd2: return (yr[1:0] == 2'b00) ? 8'd29 : 8'd28;
      8'd4, 8'd6, 8'd9, 8'd11: return 8'd30;
      default: return 8'd31;
    endcase
  endfunction
  // Rate code to divider bit; codes 1 and 2 repeat codes 8 and 9
  function automatic logic [3:0] tapOf(input logic [3:0] rs);
    case (rs)
      4'h1: return 4'h6;
      4'h2: return 4'h7;
      default: return 4'(rs - 4'h2);
    endcase
  endfunction

  logic [25:0] accReg;
  logic oscTick;
  logic [14:0] divReg;
  logic [14:0] divNext;
  logic [7:0] rateCtrlReg;
  logic [7:0] modeCtrlReg;
  logic [7:0] flagsReg;
  logic [7:0] reportedReg;
  logic pendingReg;
  logic dirtyReg;
  brc_pkg::brc_state_e stateReg;
  logic [7:0] userB [0:brc_pkg::CLOCK_BYTES-1];
  logic [7:0] locB [0:brc_pkg::CLOCK_BYTES-1];
  logic [7:0] advB [0:brc_pkg::CLOCK_BYTES-1];
  logic [7:0] storeMem [0:brc_pkg::STORAGE_BYTES-1];
  logic [7:0] idx;
  logic setup;
  logic apbDone;
  logic wrEn;
  logic readFlagsDone;
  logic [7:0] readByte;
  logic useUser;
  logic alarmHit;
  logic [3:0] tap;
  logic pfEv;
  logic afEv;
  logic ufEv;
  logic intfEv;
  logic inhibit;
  logic bin;
  logic h24;

  assign inhibit = modeCtrlReg[brc_pkg::MC_INHIBIT_BIT];
  assign bin = modeCtrlReg[brc_pkg::MC_BINARY_BIT];
  assign h24 = modeCtrlReg[brc_pkg::MC_HOUR24_BIT];
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign apbDone = psel & penable & pready;
  assign wrEn = apbDone & pwrite & pstrb[0] & ~pslverr;
  assign readFlagsDone = apbDone & ~pwrite & (idx == brc_pkg::IDX_EVENT_FLAGS);

  // Oscillator tick from a fractional accumulator; average rate is exact
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      accReg <= 26'h0;
    end else if (accReg + ACC_STEP >= ACC_LIMIT) begin
      accReg <= 26'(accReg + ACC_STEP - ACC_LIMIT);
    end else begin
      accReg <= 26'(accReg + ACC_STEP);
    end
  end
  assign oscTick = (accReg + ACC_STEP >= ACC_LIMIT);

  // Fifteen-bit divider wraps once per second
  assign divNext = 15'(divReg + 15'h1);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      divReg <= 15'h0;
    end else if (oscTick) begin
      divReg <= divNext;
    end
  end

  // Tap selector feeds both the pin and the periodic event
  assign tap = tapOf(rateCtrlReg[3:0]);
  assign pfEv = oscTick && (rateCtrlReg[3:0] != 4'h0) && divNext[tap] && !divReg[tap];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      squareWaveOut <= 1'b0;
    end else begin
      squareWaveOut <= modeCtrlReg[brc_pkg::MC_SQW_EN_BIT] && (rateCtrlReg[3:0] != 4'h0)
                       && divReg[tap];
    end
  end

  // Next second computed from the working copy, or the host copy after a reload
  assign useUser = dirtyReg & ~inhibit;
  always_comb begin
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic [7:0] wd;
    logic [7:0] md;
    logic [7:0] mo;
    logic [7:0] yr;
    s = toBin(useUser ? userB[0] : locB[0], bin);
    m = toBin(useUser ? userB[2] : locB[2], bin);
    h = hourToBin(useUser ? userB[4] : locB[4], bin, h24);
    wd = useUser ? userB[6] : locB[6];
    md = toBin(useUser ? userB[7] : locB[7], bin);
    mo = toBin(useUser ? userB[8] : locB[8], bin);
    yr = toBin(useUser ? userB[9] : locB[9], bin);
    if (s >= 8'd59) begin
      s = 8'd0;
      if (m >= 8'd59) begin
        m = 8'd0;
        if (h >= 8'd23) begin
          h = 8'd0;
          wd = (wd >= 8'd7) ? 8'd1 : 8'(wd + 8'd1);
          if (md >= daysIn(mo, yr)) begin
            md = 8'd1;
            if (mo >= 8'd12) begin
              mo = 8'd1;
              yr = (yr >= 8'd99) ? 8'd0 : 8'(yr + 8'd1);
            end else begin
              mo = 8'(mo + 8'd1);
            end
          end else begin
            md = 8'(md + 8'd1);
          end
        end else begin
          h = 8'(h + 8'd1);
        end
      end else begin
        m = 8'(m + 8'd1);
      end
    end else begin
      s = 8'(s + 8'd1);
    end
    advB[0] = fromBin(s, bin);
    advB[1] = userB[1];
    advB[2] = fromBin(m, bin);
    advB[3] = userB[3];
    advB[4] = binToHour(h, bin, h24);
    advB[5] = userB[5];
    advB[6] = wd;
    advB[7] = fromBin(md, bin);
    advB[8] = fromBin(mo, bin);
    advB[9] = fromBin(yr, bin);
  end

  // Alarm bytes with both top bits set take no part in the compare
  assign alarmHit = ((userB[1][7:6] == 2'b11) || (userB[1] == advB[0]))
                 && ((userB[3][7:6] == 2'b11) || (userB[3] == advB[2]))
                 && ((userB[5][7:6] == 2'b11) || (userB[5] == advB[4]));
  assign afEv = (stateReg == brc_pkg::ST_ADVANCE) && alarmHit;
  assign ufEv = (stateReg == brc_pkg::ST_DONE);
  assign intfEv = (pfEv & modeCtrlReg[brc_pkg::MC_PERIODIC_EN_BIT])
               | (afEv & modeCtrlReg[brc_pkg::MC_ALARM_EN_BIT])
               | (ufEv & modeCtrlReg[brc_pkg::MC_UPDATE_EN_BIT] & ~inhibit);

  // Update sequencer; the transfer step waits out any host access in flight
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stateReg <= brc_pkg::ST_IDLE;
    end else begin
      case (stateReg)
        brc_pkg::ST_IDLE: begin
          if (oscTick && divReg == brc_pkg::DIV_LAST) begin
            stateReg <= brc_pkg::ST_ADVANCE;
          end
        end
        brc_pkg::ST_ADVANCE: stateReg <= brc_pkg::ST_TRANSFER;
        brc_pkg::ST_TRANSFER: begin
          if (inhibit || !psel) begin
            stateReg <= brc_pkg::ST_DONE;
          end
        end
        brc_pkg::ST_DONE: stateReg <= brc_pkg::ST_IDLE;
        default: stateReg <= brc_pkg::ST_IDLE;
      endcase
    end
  end

  // Pending status: raised a lead before the update, dropped when it ends
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pendingReg <= 1'b0;
    end else if (oscTick && divReg == brc_pkg::DIV_LEAD_START) begin
      pendingReg <= 1'b1;
    end else if (stateReg == brc_pkg::ST_DONE) begin
      pendingReg <= 1'b0;
    end
  end

  // Working copy keeps counting regardless of inhibit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < brc_pkg::CLOCK_BYTES; i++) begin
        locB[i] <= brc_pkg::RST_CLOCK_BYTES[8*i +: 8];
      end
    end else if (stateReg == brc_pkg::ST_ADVANCE) begin
      for (int i = 0; i < brc_pkg::CLOCK_BYTES; i++) begin
        locB[i] <= advB[i];
      end
    end
  end

  // Host copy: written by the host, refreshed by the transfer step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < brc_pkg::CLOCK_BYTES; i++) begin
        userB[i] <= brc_pkg::RST_CLOCK_BYTES[8*i +: 8];
      end
    end else if (stateReg == brc_pkg::ST_TRANSFER && !inhibit && !psel) begin
      for (int i = 0; i < brc_pkg::CLOCK_BYTES; i++) begin
        if (i != 1 && i != 3 && i != 5) begin
          userB[i] <= locB[i];
        end
      end
    end else if (wrEn && !powerFail && idx < 8'(brc_pkg::CLOCK_BYTES)) begin
      userB[idx[3:0]] <= pwdata[7:0];
    end
  end

  // Host-written time bytes reload the working copy at the next free update
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dirtyReg <= 1'b0;
    end else if (wrEn && !powerFail && idx < 8'(brc_pkg::CLOCK_BYTES)) begin
      dirtyReg <= 1'b1;
    end else if (stateReg == brc_pkg::ST_ADVANCE && useUser) begin
      dirtyReg <= 1'b0;
    end
  end

  // Battery-backed storage; no reset, contents survive
  always_ff @(posedge sys_clk) begin
    if (wrEn && !powerFail && idx >= brc_pkg::IDX_STORAGE_FIRST) begin
      storeMem[8'(idx - brc_pkg::IDX_STORAGE_FIRST)] <= pwdata[7:0];
    end
  end

  // Control bytes stay writable under power failure
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rateCtrlReg <= brc_pkg::RST_RATE_CTRL;
      modeCtrlReg <= brc_pkg::RST_MODE_CTRL;
    end else if (wrEn && idx == brc_pkg::IDX_RATE_CTRL) begin
      rateCtrlReg <= pwdata[7:0];
    end else if (wrEn && idx == brc_pkg::IDX_MODE_CTRL) begin
      modeCtrlReg <= pwdata[7:0];
    end
  end

  // Flags: only bits already shown to the host are cleared, so a new event wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flagsReg <= 8'h00;
    end else begin
      flagsReg <= (flagsReg & ~(readFlagsDone ? reportedReg : 8'h00))
                | {intfEv, pfEv, afEv, ufEv, 4'h0};
    end
  end

  // Open-drain request: driven low while asserted, released on a flag read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqOe <= 1'b0;
      irqOut <= 1'b0;
    end else if (intfEv) begin
      irqOe <= 1'b1;
    end else if (readFlagsDone) begin
      irqOe <= 1'b0;
    end
  end

  // Read mux over the single byte space
  always_comb begin
    if (idx < 8'(brc_pkg::CLOCK_BYTES)) begin
      readByte = userB[idx[3:0]];
    end else begin
      case (idx)
        brc_pkg::IDX_RATE_CTRL: readByte = {pendingReg, rateCtrlReg[6:0]};
        brc_pkg::IDX_MODE_CTRL: readByte = modeCtrlReg;
        brc_pkg::IDX_EVENT_FLAGS: readByte = flagsReg;
        brc_pkg::IDX_POWER_STATUS: readByte = {~powerFail, 7'h00};
        default: readByte = storeMem[8'(idx - brc_pkg::IDX_STORAGE_FIRST)];
      endcase
    end
  end

  // APB slave: read data captured in the setup cycle, one access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      reportedReg <= 8'h00;
    end else begin
      pready <= setup;
      pslverr <= setup && (paddr[11:10] != 2'b00);
      if (setup) begin
        prdata <= {24'h0, (paddr[11:10] != 2'b00) ? 8'h00 : readByte};
        reportedReg <= (idx == brc_pkg::IDX_EVENT_FLAGS) ? flagsReg : 8'h00;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence updStart;
    stateReg == brc_pkg::ST_IDLE && oscTick && divReg == brc_pkg::DIV_LAST;
  endsequence
  sequence flagRead;
    readFlagsDone && !intfEv;
  endsequence

  AST_PENDING_BEFORE_UPDATE: assert property (updStart |-> pendingReg)
    else $error("update started without pending status");
  AST_DONE_CLEARS_PENDING: assert property (updStart ##1 1'b1 ##1 (stateReg == brc_pkg::ST_TRANSFER)
    ##[1:300] (stateReg == brc_pkg::ST_DONE) |=> !pendingReg && flagsReg[brc_pkg::EF_UPDATE_BIT])
    else $error("update end did not clear pending or set flag");
  AST_ALARM_IN_UPDATE: assert property ($rose(flagsReg[brc_pkg::EF_ALARM_BIT])
    |-> $past(stateReg) == brc_pkg::ST_ADVANCE)
    else $error("alarm flag set outside update");
  AST_INHIBIT_FREEZES: assert property ((stateReg == brc_pkg::ST_TRANSFER && inhibit)
    |=> userB[0] == $past(userB[0]))
    else $error("visible seconds changed while inhibited");
  AST_TRANSFER_COPIES: assert property ((stateReg == brc_pkg::ST_TRANSFER && !inhibit && !psel)
    |=> userB[0] == $past(locB[0]) && userB[9] == $past(locB[9]))
    else $error("transfer did not copy working bytes");
  AST_HOLD_DURING_ACCESS: assert property ((stateReg == brc_pkg::ST_TRANSFER && !inhibit && psel)
    |=> stateReg == brc_pkg::ST_TRANSFER)
    else $error("transfer ran during a host access");
  AST_POWERFAIL_BLOCKS: assert property ((wrEn && powerFail && idx == brc_pkg::IDX_TIME_SECONDS
    && stateReg != brc_pkg::ST_TRANSFER) |=> $stable(userB[0]))
    else $error("write landed during power failure");
  AST_READ_RELEASES: assert property (flagRead |=> !irqOe && flagsReg[brc_pkg::EF_SUMMARY_BIT]
    == 1'b0 || $past(flagsReg[brc_pkg::EF_SUMMARY_BIT]) != $past(reportedReg[7]))
    else $error("flag read left request asserted");
  AST_UPDATE_IRQ_GATE: assert property ((ufEv && inhibit && !pfEv && !flagsReg[7])
    |=> !flagsReg[brc_pkg::EF_SUMMARY_BIT])
    else $error("update request raised while inhibited");
  AST_RATE_ZERO_QUIET: assert property ((rateCtrlReg[3:0] == 4'h0)[*2] |-> !squareWaveOut)
    else $error("square wave active with rate zero");
endmodule

// ---- hdl/brc_pkg.sv ----
// Shared constants and types for the battery-backed real-time clock core
package brc_pkg;
  // Byte indices of the clock space; byte address on the bus is four times the index
  localparam logic [7:0] IDX_TIME_SECONDS = 8'h00;
  localparam logic [7:0] IDX_ALARM_SECONDS = 8'h01;
  localparam logic [7:0] IDX_TIME_MINUTES = 8'h02;
  localparam logic [7:0] IDX_ALARM_MINUTES = 8'h03;
  localparam logic [7:0] IDX_TIME_HOURS = 8'h04;
  localparam logic [7:0] IDX_ALARM_HOURS = 8'h05;
  localparam logic [7:0] IDX_WEEKDAY = 8'h06;
  localparam logic [7:0] IDX_MONTH_DAY = 8'h07;
  localparam logic [7:0] IDX_CALENDAR_MONTH = 8'h08;
  localparam logic [7:0] IDX_CALENDAR_YEAR = 8'h09;
  localparam logic [7:0] IDX_RATE_CTRL = 8'h0a;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h0b;
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_POWER_STATUS = 8'h0d;
  localparam logic [7:0] IDX_STORAGE_FIRST = 8'h0e;
  localparam int CLOCK_BYTES = 10;
  localparam int STORAGE_BYTES = 242;
  // Rate control: low nibble selects the divider tap, bit 7 reads update pending
  localparam int RC_PENDING_BIT = 7;
  // Mode control bit positions
  localparam int MC_INHIBIT_BIT = 7;
  localparam int MC_PERIODIC_EN_BIT = 6;
  localparam int MC_ALARM_EN_BIT = 5;
  localparam int MC_UPDATE_EN_BIT = 4;
  localparam int MC_SQW_EN_BIT = 3;
  localparam int MC_BINARY_BIT = 2;
  localparam int MC_HOUR24_BIT = 1;
  // Event flag bit positions
  localparam int EF_SUMMARY_BIT = 7;
  localparam int EF_PERIODIC_BIT = 6;
  localparam int EF_ALARM_BIT = 5;
  localparam int EF_UPDATE_BIT = 4;
  localparam int PS_VALID_BIT = 7;
  // Reset values
  localparam logic [7:0] RST_RATE_CTRL = 8'h06;
  localparam logic [7:0] RST_MODE_CTRL = 8'h02;
  // Time bytes after reset, byte i at bits 8*i; 00:00:00, Sunday 1st January year 00
  localparam logic [79:0] RST_CLOCK_BYTES = 80'h00_01_01_01_00_00_00_00_00_00;
  // Timebase
  localparam int OSC_HZ = 32768;
  localparam int UPDATE_PERIOD_S = 1;
  localparam int OSC_TICKS_PER_UPDATE = OSC_HZ * UPDATE_PERIOD_S;
  localparam int DIV_BITS = 15;
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  localparam int LEAD_US = 244;
  localparam int LEAD_TICKS = (LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam logic [14:0] DIV_LEAD_START = 15'(OSC_TICKS_PER_UPDATE - LEAD_TICKS);
  // Update sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADVANCE = 4'b0010,
    ST_TRANSFER = 4'b0100,
    ST_DONE = 4'b1000
  } brc_state_e;
endpackage

// ---- testbench/brc_host_model.sv ----
// Host processor model that reaches the clock core bytes over APB
`timescale 1ns/100ps
module brc_host_model (
  input wire logic sys_clk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus starts idle with defined levels
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
  end

  // One byte per transfer, request held until pready is sampled high or 16 cycles pass
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err, output logic ok);
    int n;
    @(posedge sys_clk);
    paddr <= addr;
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 16) begin
      @(posedge sys_clk);
      n++;
      ok = (pready === 1'b1);
    end
    rd = prdata[7:0];
    err = pslverr;
    // Released lines are inverted so stale values never pass for fresh ones
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~addr;
    pwdata <= ~pwdata;
  endtask
endmodule

// ---- testbench/brc_rtc_core_bench.sv ----
// Self-checking bench for the real-time clock core
`timescale 1ns/100ps
module brc_rtc_core_bench;
  // Byte i at bits 8*i: 23:59:59 Saturday 28 Feb year 00, alarms 00:00:00
  localparam logic [79:0] SET_BYTES = 80'h00_02_28_07_00_23_00_59_00_59;
  localparam logic [79:0] EXP_BYTES = 80'h00_02_29_01_00_00_00_00_00_00;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic powerFail = 1'b0;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic squareWaveOut;
  logic irqOut;
  logic irqOe;
  logic [7:0] rdata;
  logic err;
  logic ok;
  logic prevSq;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;
  int edges;

  // Clock and free-running cycle count
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // One oscillator tick per clock keeps a second at 32768 cycles
  brc_rtc_core #(.CLK_HZ(32768)) i_brc_rtc_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerFail(powerFail), .squareWaveOut(squareWaveOut), .irqOut(irqOut), .irqOe(irqOe));

  brc_host_model i_brc_host_model (.sys_clk(sys_clk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // A transfer that never completes ends the run as a failure
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
    i_brc_host_model.xfer(wr, addr, wd, rdata, err, ok);
    if (!ok) begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic wrB(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, {2'b00, idx, 2'b00}, d);
  endtask

  task automatic rdB(input logic [7:0] idx);
    xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
  endtask

  // Polls the pending status; the bound covers well over one second
  task automatic waitPend(input logic lvl);
    int n;
    n = 0;
    rdB(brc_pkg::IDX_RATE_CTRL);
    while (rdata[brc_pkg::RC_PENDING_BIT] !== lvl && n < 20000) begin
      rdB(brc_pkg::IDX_RATE_CTRL);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      finish_test();
    end
  endtask

  // Counts square-wave rising edges over 400 cycles for one rate code
  task automatic sqCount(input logic [7:0] rate, input int lo, input int hi);
    wrB(brc_pkg::IDX_RATE_CTRL, rate);
    edges = 0;
    prevSq = squareWaveOut;
    repeat (400) begin
      @(posedge sys_clk);
      if (squareWaveOut && !prevSq) edges++;
      prevSq = squareWaveOut;
    end
    chk({7'h00, (edges >= lo && edges <= hi)}, 8'h01);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rdB(8'(i));
      chk(rdata, brc_pkg::RST_CLOCK_BYTES[8*i +: 8]);
    end
    rdB(brc_pkg::IDX_RATE_CTRL);
    chk(rdata, brc_pkg::RST_RATE_CTRL);
    rdB(brc_pkg::IDX_MODE_CTRL);
    chk(rdata, brc_pkg::RST_MODE_CTRL);
    rdB(brc_pkg::IDX_EVENT_FLAGS);
    chk(rdata & 8'hb0, 8'h00);
    xfer(1'b0, 12'h400, 8'h00);
    chk({7'h00, err}, 8'h01);
    chk(rdata, 8'h00);
    // Writes on back-up power must leave storage and time untouched
    wrB(brc_pkg::IDX_STORAGE_FIRST, 8'ha5);
    powerFail <= 1'b1;
    wrB(brc_pkg::IDX_STORAGE_FIRST, 8'h5a);
    wrB(brc_pkg::IDX_TIME_SECONDS, 8'h30);
    rdB(brc_pkg::IDX_POWER_STATUS);
    chk({7'h00, rdata[brc_pkg::PS_VALID_BIT]}, 8'h00);
    rdB(brc_pkg::IDX_STORAGE_FIRST);
    chk(rdata, 8'ha5);
    rdB(brc_pkg::IDX_TIME_SECONDS);
    chk(rdata, 8'h00);
    powerFail <= 1'b0;
    wrB(brc_pkg::IDX_MODE_CTRL, 8'h0a);
    sqCount(8'h03, 99, 101);
    sqCount(8'h00, 0, 0);
    sqCount(8'h0f, 0, 1);
    // Set the clock under inhibit, then release with update events enabled
    wrB(brc_pkg::IDX_MODE_CTRL, 8'h82);
    for (int i = 0; i < 10; i++) wrB(8'(i), SET_BYTES[8*i +: 8]);
    wrB(brc_pkg::IDX_MODE_CTRL, 8'h12);
    waitPend(1'b1);
    t0 = cyc;
    waitPend(1'b0);
    chk({7'h00, irqOe}, 8'h01);
    chk({7'h00, irqOut}, 8'h00);
    rdB(brc_pkg::IDX_EVENT_FLAGS);
    chk(rdata & 8'hb0, 8'hb0);
    @(posedge sys_clk);
    chk({7'h00, irqOe}, 8'h00);
    rdB(brc_pkg::IDX_EVENT_FLAGS);
    chk(rdata & 8'hb0, 8'h00);
    for (int i = 0; i < 10; i++) begin
      rdB(8'(i));
      chk(rdata, EXP_BYTES[8*i +: 8]);
    end
    // Inhibit freezes the visible copy while the working copy keeps counting
    wrB(brc_pkg::IDX_MODE_CTRL, 8'h92);
    waitPend(1'b1);
    chk({7'h00, (cyc - t0 >= 32760 && cyc - t0 <= 32776)}, 8'h01);
    waitPend(1'b0);
    chk({7'h00, irqOe}, 8'h00);
    rdB(brc_pkg::IDX_TIME_SECONDS);
    chk(rdata, 8'h00);
    rdB(brc_pkg::IDX_EVENT_FLAGS);
    chk(rdata & 8'hb0, 8'h10);
    wrB(brc_pkg::IDX_MODE_CTRL, 8'h12);
    waitPend(1'b1);
    waitPend(1'b0);
    rdB(brc_pkg::IDX_TIME_SECONDS);
    chk(rdata, 8'h02);
    finish_test();
  end
endmodule
